// ===== design/adc_link_pkg.sv
package adc_link_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int          WORD_BITS     = 16;     // Bits per frame
  localparam int          CMD_BITS      = 4;      // Command field width
  localparam int          DATA_BITS     = 12;     // Data field width
  localparam int          PAD_BITS      = 4;      // Don't-care tail of a result
  localparam logic [3:0]  PAD_VALUE     = 4'h0;   // Value sent in the tail
  localparam logic [4:0]  EDGE_LIMIT    = 5'h10;  // Edges per frame
  localparam logic [4:0]  LAST_EDGE     = 5'h0f;  // Edge count at the last bit
  localparam logic [4:0]  CHAN_EDGES    = 5'h04;  // Edges before channel is chosen
  localparam logic [3:0]  CMD_CFG_WRITE = 4'ha;   // Configuration write command
  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CFG_RESET     = 12'h000; // Configuration after reset
  localparam int          CFG_MODE_LSB  = 0;       // Conversion mode, two bits
  localparam int          CFG_INT_SEL   = 2;       // 1: interrupt, 0: end of conversion
  localparam int          CFG_SCLK_CONV = 3;       // 1: serial clock drives conversion
  localparam logic [1:0]  MODE_SINGLE   = 2'h0;    // Conversion mode 00
  localparam logic [1:0]  MODE_SELECT   = 2'h1;    // Conversion mode 01
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLOCK_NS      = 100;     // System clock period
  localparam int          SCLK_HALF_NS  = 800;     // Host serial clock half period
  localparam int          SCLK_HALF     = SCLK_HALF_NS / CLOCK_NS; // Cycles per half
  localparam int          FIFO_DEPTH    = 16;      // Received word buffer depth
  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE, HS_PREP, HS_LEAD, HS_FSHI, HS_LOW, HS_HIGH, HS_TAIL
  } host_state_t;
endpackage : adc_link_pkg

// ===== design/adc_link_if.sv
`timescale 1ns/1ns
interface adc_link_if;
  logic cs_n;          // Device select, host driven
  logic sclk;          // Serial clock, host driven
  logic serial_in;     // Data toward the converter
  logic frame_sync;    // Frame sync, host driven
  logic sample_start_n; // Sample start, host driven
  logic power_down_n;  // Power down, host driven
  logic serial_out;    // Converter data, valid while enabled
  logic serial_out_oe_n; // Converter output enable, low drives
  logic status_n;      // End of conversion or interrupt
  logic serial_line;   // Resolved serial out wire, pulled high when floating

  // Pull-up of the three-state line
  assign serial_line = serial_out_oe_n ? 1'b1 : serial_out;

  modport converter (
    input  cs_n, sclk, serial_in, frame_sync, sample_start_n, power_down_n,
    output serial_out, serial_out_oe_n, status_n
  );
  modport host (
    output cs_n, sclk, serial_in, frame_sync, sample_start_n, power_down_n,
    input  serial_line, status_n
  );
endinterface : adc_link_if

// ===== design/adc_converter_end.sv
// Operation
// RQ1: Select fall clears counter, enables input, output
// RQ2: Input stops at sixteen edges or select rise
// RQ3: Host moves select only while clock low
// RQ4: Sample start low period sets sampling, select high
// RQ5: Sample start rise launches conversion
// RQ6: Mode 01 early start deferred until select rises
// RQ7: End-of-conversion low from sampling end to data; code does this in mode 00 only, holds it high in other modes
// RQ8: Interrupt falls on data, cleared by select/sync
// RQ9: Sync low at select fall waits for sync
// RQ10: Sync fall clears counter, enables input
// RQ11: Power down off; wake on select, sync, start
// RQ12: Clock shifts input; optional conversion clock source
// RQ13: Host holds serial clock low when idle
// RQ14: Input MSB first, top four bits command
// RQ15: Configuration write carries twelve data bits
// RQ16: Plain frames capture on rising clock edges
// RQ17: Sync frames capture on falling clock edges
// RQ18: High source impedance: use start or long
// RQ19: Plain frames change output on falling edge
// RQ20: Sync frames change output on rising edge
// RQ21: Result twelve bits, four pad, then float
// RQ22: Sync level at select fall picks frame type
`timescale 1ns/1ns
module adc_word_fifo
  import adc_link_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             CLOCK_I,
  input  wire logic             RST_B_I,
  input  wire logic [WIDTH-1:0] WR_DATA_I,
  input  wire logic             WR_VALID_I,
  output logic                  WR_READY_O,
  output logic      [WIDTH-1:0] RD_DATA_O,
  output logic                  RD_VALID_O,
  input  wire logic             RD_READY_I
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Word storage
  logic [AW:0]      wr_ptr;       // Write pointer with wrap bit
  logic [AW:0]      rd_ptr;       // Read pointer with wrap bit
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = WR_VALID_I && !full;
  wire              pop   = RD_READY_I && !empty;

  assign WR_READY_O = !full;
  assign RD_VALID_O = !empty;
  assign RD_DATA_O  = mem[rd_ptr[AW-1:0]];

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= WR_DATA_I;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : adc_word_fifo

module adc_converter_end
  import adc_link_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_B_I,
  adc_link_if.converter             LINK,
  input  wire logic [DATA_BITS-1:0] RESULT_I,        // Conversion result from core
  input  wire logic                 RESULT_VALID_I,  // Result ready pulse
  output logic                      SAMPLING_O,      // Sampling switch closed
  output logic                      CONVERT_O,       // Conversion launch pulse
  output logic                      ANALOG_ON_O,     // Analog and reference powered
  output logic                      CONV_CLK_SCLK_O, // Serial clock is conversion clock
  output logic [DATA_BITS-1:0]      CFG_O,           // Configuration register
  output logic [WORD_BITS-1:0]      WORD_O,          // Received word
  output logic                      WORD_VALID_O,
  input  wire logic                 WORD_READY_I
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1;  // First stage, read only by sync2
  logic [5:0] sync2;  // Second stage
  logic [5:0] prev;   // Delayed copy for edge finding

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      // Idle pin levels: select high, clock low, sync high, start high, power on
      sync1 <= 6'h27;
      sync2 <= 6'h27;
      prev  <= 6'h27;
    end else begin
      sync1 <= {LINK.cs_n, LINK.sclk, LINK.serial_in, LINK.frame_sync,
                LINK.sample_start_n, LINK.power_down_n};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  wire cs_s      = sync2[5];          // Select level, high idle
  wire sdi_s     = sync2[3];          // Serial input level
  wire fs_s      = sync2[2];          // Frame sync level
  wire cst_s     = sync2[1];          // Sample start level
  wire pwr_s     = sync2[0];          // Power level, low powers down
  wire cs_fall   = prev[5] && !sync2[5];
  wire cs_rise   = !prev[5] && sync2[5];
  wire sck_rise  = !prev[4] && sync2[4];
  wire sck_fall  = prev[4] && !sync2[4];
  wire fs_fall   = prev[2] && !sync2[2];
  wire cst_fall  = prev[1] && !sync2[1];
  wire cst_rise  = !prev[1] && sync2[1];

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  logic                 fs_mode;   // Frame uses sync
  logic                 frame_on;  // Frame running
  logic                 in_en;     // Serial input accepted
  logic                 out_en;    // Serial output driven
  logic [4:0]           edge_cnt;  // Capture edges this frame
  logic [WORD_BITS-1:0] shift_in;  // Incoming word
  logic [WORD_BITS-1:0] shift_out; // Outgoing word
  logic [DATA_BITS-1:0] result;    // Last conversion result
  logic                 fifo_ready;
  logic                 push;      // Word complete pulse
  logic [WORD_BITS-1:0] word;      // Completed word

  wire plain_start = cs_fall && fs_s;                        // RQ22
  wire sync_start  = fs_fall && !cs_s;                       // RQ9
  wire frame_start = plain_start || sync_start;
  wire cap_edge    = fs_mode ? sck_fall : sck_rise;          // RQ16 RQ17
  wire drv_edge    = fs_mode ? sck_rise : sck_fall;          // RQ19 RQ20
  wire counting    = frame_on && cap_edge && (edge_cnt != EDGE_LIMIT);
  wire last_bit    = counting && (edge_cnt == LAST_EDGE);
  wire [WORD_BITS-1:0] next_shift_in = {shift_in[WORD_BITS-2:0], sdi_s};
  wire [CMD_BITS-1:0]  next_cmd      = next_shift_in[WORD_BITS-1 -: CMD_BITS];

  // Frame start, edge counting and input shifting
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fs_mode  <= 1'b0;
      frame_on <= 1'b0;
      in_en    <= 1'b0;
      edge_cnt <= '0;
      shift_in <= '0;
      push     <= 1'b0;
      word     <= '0;
    end else begin
      push <= 1'b0;
      if (cs_fall) begin
        fs_mode <= !fs_s;                                    // RQ22
      end
      if (cs_rise) begin
        frame_on <= 1'b0;                                    // RQ2
        in_en    <= 1'b0;                                    // RQ2
      end else if (frame_start) begin
        frame_on <= 1'b1;
        in_en    <= fifo_ready;                              // RQ1 RQ10
        edge_cnt <= '0;                                      // RQ1 RQ10
      end else if (counting) begin
        edge_cnt <= edge_cnt + 1'b1;
        if (in_en) begin
          shift_in <= next_shift_in;                         // RQ12 RQ14
        end
        if (last_bit) begin
          in_en <= 1'b0;                                     // RQ2
          push  <= in_en;
          word  <= next_shift_in;
        end
      end
    end
  end

  // Configuration capture on write command
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CFG_O <= CFG_RESET;
    end else if (last_bit && in_en && next_cmd == CMD_CFG_WRITE) begin
      CFG_O <= next_shift_in[DATA_BITS-1:0];                 // RQ15
    end
  end

  // Output shifter: result, then pad, then float
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      out_en    <= 1'b0;
      shift_out <= '0;
    end else if (cs_rise) begin
      out_en <= 1'b0;
    end else if (frame_start) begin
      out_en    <= 1'b1;                                     // RQ1
      shift_out <= {result, PAD_VALUE};                      // RQ21
    end else if (frame_on && drv_edge && edge_cnt != 5'h00) begin
      if (edge_cnt == EDGE_LIMIT) begin
        out_en <= 1'b0;                                      // RQ21
      end
      shift_out <= {shift_out[WORD_BITS-2:0], 1'b0};         // RQ19 RQ20
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      LINK.serial_out      <= 1'b0;
      LINK.serial_out_oe_n <= 1'b1;
    end else begin
      LINK.serial_out      <= shift_out[WORD_BITS-1];
      LINK.serial_out_oe_n <= !out_en;
    end
  end

  // ----------------------------------------------------------------
  // Sampling, conversion and status
  // ----------------------------------------------------------------
  logic armed;  // Early start seen during select cycle
  wire  mode01    = CFG_O[CFG_MODE_LSB +: 2] == MODE_SELECT;
  wire  mode00    = CFG_O[CFG_MODE_LSB +: 2] == MODE_SINGLE;
  wire  samp_go   = (cs_s && cst_fall) || (mode01 && cs_rise && armed && !cst_s);
  wire  samp_end  = cs_s && cst_rise && SAMPLING_O;
  wire  int_sel   = CFG_O[CFG_INT_SEL];
  wire  int_clear = cs_fall || fs_fall;

  // Sampling window and conversion launch
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      armed      <= 1'b0;
      SAMPLING_O <= 1'b0;
      CONVERT_O  <= 1'b0;
    end else begin
      CONVERT_O <= samp_end;                                 // RQ5
      if (!cs_s && cst_fall && edge_cnt >= CHAN_EDGES) begin
        armed <= 1'b1;                                       // RQ6
      end else if (cs_rise || cs_s) begin
        armed <= 1'b0;
      end
      if (samp_go) begin
        SAMPLING_O <= 1'b1;                                  // RQ4 RQ6
      end else if (samp_end) begin
        SAMPLING_O <= 1'b0;                                  // RQ4
      end
    end
  end

  // Status pin; new data wins over a clear in the same cycle
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      LINK.status_n <= 1'b1;
      result        <= '0;
    end else begin
      if (RESULT_VALID_I) begin
        result <= RESULT_I;
      end
      if (int_sel) begin
        if (RESULT_VALID_I) begin
          LINK.status_n <= 1'b0;                             // RQ8
        end else if (int_clear) begin
          LINK.status_n <= 1'b1;                             // RQ8
        end
      end else if (mode00 && samp_end) begin
        LINK.status_n <= 1'b0;                               // RQ7
      end else if (RESULT_VALID_I || !mode00) begin
        LINK.status_n <= 1'b1;                               // RQ7
      end
    end
  end

  // Power control and conversion clock select
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ANALOG_ON_O     <= 1'b1;
      CONV_CLK_SCLK_O <= 1'b0;
    end else begin
      CONV_CLK_SCLK_O <= CFG_O[CFG_SCLK_CONV];               // RQ12
      if (!pwr_s) begin
        ANALOG_ON_O <= 1'b0;                                 // RQ11
      end else if (cs_fall || fs_fall || cst_fall) begin
        ANALOG_ON_O <= 1'b1;                                 // RQ11
      end
    end
  end

  // ----------------------------------------------------------------
  // Received word buffer; a full buffer refuses the words of new frames
  // ----------------------------------------------------------------
  adc_word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .CLOCK_I    (CLOCK_I),
    .RST_B_I    (RST_B_I),
    .WR_DATA_I  (word),
    .WR_VALID_I (push),
    .WR_READY_O (fifo_ready),
    .RD_DATA_O  (WORD_O),
    .RD_VALID_O (WORD_VALID_O),
    .RD_READY_I (WORD_READY_I)
  );
endmodule : adc_converter_end

// ===== design/adc_host_end.sv
`timescale 1ns/1ns
module adc_host_end
  import adc_link_pkg::*;
#(
  parameter int HALF = SCLK_HALF  // System cycles per serial clock half
) (
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_B_I,
  adc_link_if.host                  LINK,
  input  wire logic                 START_I,         // Begin one frame
  input  wire logic                 FS_MODE_I,       // Use frame sync
  input  wire logic [WORD_BITS-1:0] WORD_I,          // Word to send
  input  wire logic                 SAMPLE_START_N_I, // Sample start request
  input  wire logic                 POWER_DOWN_N_I,  // Power request
  output logic                      BUSY_O,
  output logic      [WORD_BITS-1:0] RESULT_O,        // Word read back
  output logic                      DONE_O,          // Frame finished pulse
  output logic                      STATUS_N_O       // Synchronised status pin
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync1;  // First stage, read only by sync2
  logic [1:0] sync2;  // Second stage

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end else begin
      sync1 <= {LINK.serial_line, LINK.status_n};
      sync2 <= sync1;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  host_state_t          state;
  logic [7:0]           timer;   // Cycles in this half period
  logic [4:0]           bits;    // Bits exchanged
  logic                 mode;    // Latched frame sync use
  logic [WORD_BITS-1:0] tx;      // Outgoing shifter
  logic [WORD_BITS-1:0] rx;      // Incoming shifter
  wire                  half_done = timer == 8'(HALF - 1);
  wire                  sample_in = sync2[1];

  // Pass-through of sample start and power
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      LINK.sample_start_n <= 1'b1;
      LINK.power_down_n   <= 1'b1;
      STATUS_N_O          <= 1'b1;
    end else begin
      LINK.sample_start_n <= SAMPLE_START_N_I;
      LINK.power_down_n   <= POWER_DOWN_N_I;
      STATUS_N_O          <= sync2[0];
    end
  end

  // Sequencer; select only moves while the clock is low
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state          <= HS_IDLE;
      timer          <= '0;
      bits           <= '0;
      mode           <= 1'b0;
      tx             <= '0;
      rx             <= '0;
      BUSY_O         <= 1'b0;
      DONE_O         <= 1'b0;
      RESULT_O       <= '0;
      LINK.cs_n       <= 1'b1;
      LINK.sclk       <= 1'b0;                               // RQ13
      LINK.serial_in  <= 1'b0;
      LINK.frame_sync <= 1'b1;
    end else begin
      DONE_O <= 1'b0;
      timer  <= half_done ? 8'h00 : timer + 1'b1;
      unique case (state)
        HS_IDLE: begin
          timer <= '0;
          if (START_I) begin
            mode            <= FS_MODE_I;
            tx              <= WORD_I;
            bits            <= '0;
            BUSY_O          <= 1'b1;
            LINK.frame_sync <= !FS_MODE_I;
            state           <= HS_PREP;
          end
        end
        HS_PREP: begin
          if (half_done) begin
            LINK.cs_n      <= 1'b0;                          // RQ3
            LINK.serial_in <= tx[WORD_BITS-1];               // RQ14
            state          <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (half_done) begin
            LINK.frame_sync <= 1'b1;  // Sync frames raise sync before their start fall
            state           <= mode ? HS_FSHI : HS_LOW;
          end
        end
        HS_FSHI: begin
          if (half_done) begin
            LINK.frame_sync <= 1'b0;
            state           <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (half_done) begin
            if (!mode) begin
              rx <= {rx[WORD_BITS-2:0], sample_in};
            end
            if (mode && bits != 5'h00) begin
              tx             <= {tx[WORD_BITS-2:0], 1'b0};
              LINK.serial_in <= tx[WORD_BITS-2];
            end
            LINK.sclk <= 1'b1;
            state     <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (half_done) begin
            if (mode) begin
              rx <= {rx[WORD_BITS-2:0], sample_in};
            end else begin
              tx             <= {tx[WORD_BITS-2:0], 1'b0};
              LINK.serial_in <= tx[WORD_BITS-2];
            end
            LINK.sclk <= 1'b0;
            bits      <= bits + 1'b1;
            state     <= (bits == LAST_EDGE) ? HS_TAIL : HS_LOW;
          end
        end
        HS_TAIL: begin
          if (half_done) begin
            LINK.cs_n       <= 1'b1;                         // RQ3
            LINK.frame_sync <= 1'b1;
            RESULT_O        <= rx;
            DONE_O          <= 1'b1;
            BUSY_O          <= 1'b0;
            state           <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : adc_host_end

// ===== dv/adc_link_checker.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Link checker beside the interface
// ------------------------------------------------------------
module adc_link_checker #(
  parameter int HALF = 8  // Serial clock half period in cycles
) (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic frame_sync,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic status_n
);
  int run;  // Cycles the output has been driven
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  // Length of each driven stretch
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) run <= 0;
    else run <= serial_out_oe_n ? 0 : run + 1;
  end
  property p_idle; cs_n [*6] |-> serial_out_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("output driven while idle");
  property p_start; $fell(cs_n) && frame_sync |-> ##[2:10] !serial_out_oe_n; endproperty
  a_start: assert property (p_start) else $error("output not enabled");
  property p_cpol; cs_n |-> !sclk; endproperty
  a_cpol: assert property (p_cpol) else $error("clock not idle low");
  property p_csmove; $changed(cs_n) |-> !sclk; endproperty
  a_csmove: assert property (p_csmove) else $error("select moved, clock high");
  property p_plain; $rose(sclk) && frame_sync |-> $stable(serial_out) [*4]; endproperty
  a_plain: assert property (p_plain) else $error("plain bit moved");
  property p_sync; $fell(sclk) && !frame_sync |-> $stable(serial_out) [*4]; endproperty
  a_sync: assert property (p_sync) else $error("sync bit moved");
  property p_wait; $fell(cs_n) && !frame_sync |-> serial_out_oe_n [*8]; endproperty
  a_wait: assert property (p_wait) else $error("started before sync");
  property p_fs; $fell(frame_sync) && !cs_n |-> ##[2:10] !serial_out_oe_n; endproperty
  a_fs: assert property (p_fs) else $error("sync did not start");
  property p_len; run <= 36 * HALF; endproperty
  a_len: assert property (p_len) else $error("output not floated");
  c_plain: cover property ($fell(cs_n) && frame_sync);
  c_sync: cover property ($fell(frame_sync) && !cs_n);
  c_stat: cover property ($fell(status_n));
endmodule : adc_link_checker

// ===== dv/adc_serial_control_front_end_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
// ------------------------------------------------------------
// Bench: host end and converter end back to back
// ------------------------------------------------------------
module adc_serial_control_front_end_tb_top
  import adc_link_pkg::*;
;
  logic clk, rst_n, start, fs, ssn, pdn, rv, rdy;
  logic [15:0] w, res_o, word_o, q[$];
  logic [11:0] res, cfg;
  logic busy, done, stn, smp, conv, aon, cck, wv;
  int num_errors = 0, n_checks = 0, cyc = 0, k;
  adc_link_if link();
  adc_host_end u_adc_host_end (.CLOCK_I(clk), .RST_B_I(rst_n), .LINK(link), .START_I(start),
    .FS_MODE_I(fs), .WORD_I(w), .SAMPLE_START_N_I(ssn), .POWER_DOWN_N_I(pdn), .BUSY_O(busy),
    .RESULT_O(res_o), .DONE_O(done), .STATUS_N_O(stn));
  adc_converter_end u_adc_converter_end (.CLOCK_I(clk), .RST_B_I(rst_n), .LINK(link),
    .RESULT_I(res), .RESULT_VALID_I(rv), .SAMPLING_O(smp), .CONVERT_O(conv),
    .ANALOG_ON_O(aon), .CONV_CLK_SCLK_O(cck), .CFG_O(cfg), .WORD_O(word_o),
    .WORD_VALID_O(wv), .WORD_READY_I(rdy));
  adc_link_checker #(.HALF(SCLK_HALF)) u_adc_link_checker (.CLOCK_I(clk), .RST_B_I(rst_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .frame_sync(link.frame_sync),
    .serial_out(link.serial_out), .serial_out_oe_n(link.serial_out_oe_n),
    .status_n(link.status_n));
  // ------------------------------------------------------------
  // Clock, hang guard and verdict
  // ------------------------------------------------------------
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Expected read-back word: result first, then the pad bits
  function automatic logic [15:0] exp_read(input logic [11:0] r);
    return {r, PAD_VALUE};
  endfunction : exp_read
  // One whole frame; returns during the done pulse
  task frame(input logic m, input logic [15:0] d);
    @(posedge clk) #1;
    start = 1; fs = m; w = d;
    @(posedge clk) #1;
    start = 0;
    `CHK(busy, 1'b1)
    do @(negedge clk); while (done !== 1'b1);
    `CHK(busy, 1'b0)
  endtask : frame
  // New conversion result from the core
  task result(input logic [11:0] r);
    @(posedge clk) #1;
    res = r; rv = 1;
    @(posedge clk) #1;
    rv = 0;
    repeat (4) @(posedge clk);
  endtask : result
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {start, fs, rv, rdy, rst_n} = '0;
    {ssn, pdn} = 2'b11;
    w = '0; res = '0;
    void'($urandom(81151));
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    // Seventeen frames into a stalled buffer; the last is refused
    for (int i = 0; i < 17; i++) begin
      result(i == 0 ? 12'hfff : 12'($urandom));
      w = i == 0 ? 16'hffff : (i == 1 ? 16'h0000 : 16'($urandom));
      if (w[15:12] == CMD_CFG_WRITE) w[12] = 1'b1;
      frame(i[0], w);
      if (i < 16) q.push_back(w);
      `CHK(res_o, exp_read(res))
    end
    for (int i = 0; i < 16; i++) begin
      `CHK(word_o, q[i])
      @(posedge clk) #1 rdy = 1;
      @(posedge clk) #1 rdy = 0;
    end
    `CHK(wv, 1'b0)
    rdy = 1;
    // Configuration write, serial clock as conversion clock
    frame(1'b1, {CMD_CFG_WRITE, 12'h008});
    `CHK(cfg, 12'h008)
    `CHK(cck, 1'b1)
    // Sample start low then high with select idle
    @(posedge clk) #1 ssn = 0;
    repeat (8) @(posedge clk);
    `CHK(smp, 1'b1)
    #1 ssn = 1;
    for (k = 0; k < 20 && conv !== 1'b1; k++) @(negedge clk);
    `CHK(conv, 1'b1)
    `CHK(smp, 1'b0)
    repeat (2) @(posedge clk);
    `CHK(link.status_n, 1'b0)
    result(12'h5a5);
    `CHK(link.status_n, 1'b1)
    // Interrupt flavour: falls on data, cleared by a frame
    frame(1'b0, {CMD_CFG_WRITE, 12'h004});
    result(12'h3c3);
    `CHK(stn, 1'b0)
    frame(1'b1, 16'h1000);
    `CHK(stn, 1'b1)
    // Mode 01: early sample start inside a frame waits for select high
    frame(1'b0, {CMD_CFG_WRITE, 12'h001});
    fork
      frame(1'b0, 16'h3000);
      begin
        repeat (150) @(posedge clk);
        #1 ssn = 0;
      end
    join
    `CHK(smp, 1'b0)
    repeat (8) @(posedge clk);
    `CHK(smp, 1'b1)
    #1 ssn = 1;
    repeat (8) @(posedge clk);
    `CHK(smp, 1'b0)
    // Power down, then wake on a select
    @(posedge clk) #1 pdn = 0;
    repeat (8) @(posedge clk);
    `CHK(aon, 1'b0)
    #1 pdn = 1;
    repeat (8) @(posedge clk);
    `CHK(aon, 1'b0)
    frame(1'b0, 16'h2000);
    `CHK(aon, 1'b1)
    print_verdict();
  end
endmodule : adc_serial_control_front_end_tb_top
